// File: dosc_top.sv
// Functional notes
// - spread_en high applies dither to the master oscillator.
// - spread_en low removes all dither, giving a plain clock.
// - out_gate high enables the clock output buffer.
// - out_gate low disables output while the oscillator keeps running.
// - osc_sleep_n high keeps the master oscillator running.
// - osc_sleep_n low stops the oscillator and enters power-down.
// - serial data sampled on rising scl, changed after falling scl.
// - sda is only ever pulled low, open-drain style.
// - startup delay after power-down, then host waits frequency settle time.
// - output frequency set only by offset, dac and prescale settings.
// - startup delay is 512 master oscillator cycles.
// - idle output floats when idle_drive_low is 0, low when 1.
// - output enable and power-down release synchronised, no runt pulses.
//
// The implementer's own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
`include "dosc_consts.svh"
module dosc_top #(
  parameter int ACC_W = 20,
  parameter int SETTLE_CYC = `DOSC_SETTLE_US * `DOSC_CLK_MHZ
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic spread_en,
  input wire logic out_gate,
  input wire logic osc_sleep_n,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic clk_out,
  output logic clk_out_oe_n,
  output logic [7:0] rx_byte,
  output logic rx_valid
);
  localparam logic [9:0] A_PS = {`DOSC_IDX_PRESCALE, 2'b00};
  localparam logic [9:0] A_DAC = {`DOSC_IDX_DAC, 2'b00};
  localparam logic [9:0] A_OFS = {`DOSC_IDX_OFFSET, 2'b00};
  localparam logic [9:0] A_STAT = {`DOSC_IDX_STATUS, 2'b00};
  localparam int FILT_CYC = (`DOSC_SLEEP_FILT_NS * `DOSC_CLK_MHZ + 999) / 1000;
  localparam logic [9:0] FILT_LAST = 10'(FILT_CYC - 1);
  localparam logic [9:0] START_LAST = 10'(`DOSC_STARTUP_TICKS - 1);
  localparam logic [1:0] PERIODS = 2'(`DOSC_SLEEP_PERIODS);

  dosc_if bus_if ();

  logic [15:0] ps_reg;
  logic [9:0] dac_reg;
  logic [4:0] ofs_reg;
  logic wr_pend_reg;
  logic rd_pend_reg;
  logic [9:0] addr_q_reg;
  logic hreadyout_reg;
  logic [31:0] hrdata_reg;
  dosc_pkg::dosc_pwr_t pwr_reg;
  logic [9:0] start_cnt_reg;
  logic [9:0] filt_cnt_reg;
  logic [1:0] edge_cnt_reg;
  logic lvl_q_reg;
  logic spread_q_reg;
  logic active_reg;
  logic clk_out_reg;
  logic clk_out_oe_n_reg;
  logic sda_oe_n_reg;
  logic [31:0] settle_cnt_reg;
  logic settle_done_reg;
  logic [7:0] rx_byte_reg;
  logic rx_valid_reg;

  // bus phase decode; the upper address bits are not decoded
  wire addr_phase = hsel && htrans[1] && hready;
  wire wr_ps = wr_pend_reg && (addr_q_reg == A_PS);
  wire wr_dac = wr_pend_reg && (addr_q_reg == A_DAC);
  wire wr_ofs = wr_pend_reg && (addr_q_reg == A_OFS);
  wire running = (pwr_reg == dosc_pkg::DOSC_RUN);
  wire idle_low = ps_reg[`DOSC_PS_IDLE_BIT];
  wire lvl_fall = lvl_q_reg && !bus_if.div_lvl;
  wire sleep_go = !osc_sleep_n && (filt_cnt_reg >= FILT_LAST) && (edge_cnt_reg >= PERIODS);
  wire [31:0] stat_word = {27'h000_0000, spread_q_reg, settle_done_reg, active_reg, running,
                           pwr_reg == dosc_pkg::DOSC_SLEEP};

  // read mux; unmapped addresses read as zero
  wire [31:0] rd_word = (addr_q_reg == A_PS) ? {16'h0000, ps_reg} :
                        (addr_q_reg == A_DAC) ? {16'h0000, dac_reg, 6'h00} :
                        (addr_q_reg == A_OFS) ? {24'h00_0000, 3'b111, ofs_reg} :
                        (addr_q_reg == A_STAT) ? stat_word : 32'h0000_0000;

  // oscillator configuration
  assign bus_if.osc_run = (pwr_reg != dosc_pkg::DOSC_SLEEP);
  assign bus_if.spread = spread_q_reg;
  assign bus_if.rate = ps_reg[`DOSC_PS_RATE_LSB +: 2];
  assign bus_if.pct = ps_reg[`DOSC_PS_PCT_LSB +: 3];
  assign bus_if.div = ps_reg[`DOSC_PS_DIV_LSB +: 4];
  assign bus_if.dac = dac_reg;
  assign bus_if.ofs = ofs_reg;

  // serial engine hookup; transmit byte is the high half of the prescale word
  assign bus_if.scl = scl;
  assign bus_if.sda_in = sda_in;
  assign bus_if.tx_byte = ps_reg[15:8];
  assign bus_if.tx_en = 1'b1;

  dosc_osc #(
    .ACC_W(ACC_W)
  ) u_osc (
    .clk(clk),
    .rst(rst),
    .p(bus_if.osc)
  );

  dosc_ser u_ser (
    .clk(clk),
    .rst(rst),
    .p(bus_if.ser)
  );

  // bus slave: writes take no wait, reads take one so the data comes from a flop
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_q_reg <= '0;
      hreadyout_reg <= 1'b1;
      hrdata_reg <= '0;
    end
    else
    begin
      wr_pend_reg <= addr_phase && hwrite;
      rd_pend_reg <= addr_phase && !hwrite;
      if (addr_phase)
        addr_q_reg <= haddr[9:0];
      if (addr_phase && !hwrite)
        hreadyout_reg <= 1'b0;
      else if (rd_pend_reg)
      begin
        hreadyout_reg <= 1'b1;
        hrdata_reg <= rd_word;
      end
    end
  end

  // configuration registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ps_reg <= `DOSC_PS_RST;
      dac_reg <= `DOSC_DAC_RST;
      ofs_reg <= `DOSC_OFS_RST;
    end
    else
    begin
      if (wr_ps)
        ps_reg <= {hwdata[15:6], 6'h00};
      if (wr_dac)
        dac_reg <= hwdata[`DOSC_DAC_LSB +: 10];
      if (wr_ofs)
        ofs_reg <= hwdata[4:0];
    end
  end

  // power-down deglitch: low time plus output periods seen while low
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      filt_cnt_reg <= '0;
      edge_cnt_reg <= '0;
      lvl_q_reg <= 1'b0;
    end
    else
    begin
      lvl_q_reg <= bus_if.div_lvl;
      if (osc_sleep_n || pwr_reg == dosc_pkg::DOSC_SLEEP)
      begin
        filt_cnt_reg <= '0;
        edge_cnt_reg <= '0;
      end
      else
      begin
        if (filt_cnt_reg != FILT_LAST)
          filt_cnt_reg <= filt_cnt_reg + 10'd1;
        if (lvl_fall && edge_cnt_reg != PERIODS)
          edge_cnt_reg <= edge_cnt_reg + 2'd1;
      end
    end
  end

  // power sequencing; release waits the startup count of oscillator ticks
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pwr_reg <= dosc_pkg::DOSC_STARTUP;
      start_cnt_reg <= '0;
    end
    else
    begin
      unique case (pwr_reg)
        dosc_pkg::DOSC_SLEEP:
        begin
          start_cnt_reg <= '0;
          if (osc_sleep_n)
            pwr_reg <= dosc_pkg::DOSC_STARTUP;
        end
        dosc_pkg::DOSC_STARTUP:
        begin
          if (sleep_go)
            pwr_reg <= dosc_pkg::DOSC_SLEEP;
          else if (bus_if.tick)
          begin
            start_cnt_reg <= start_cnt_reg + 10'd1;
            if (start_cnt_reg == START_LAST)
              pwr_reg <= dosc_pkg::DOSC_RUN;
          end
        end
        dosc_pkg::DOSC_RUN:
        begin
          if (sleep_go)
            pwr_reg <= dosc_pkg::DOSC_SLEEP;
        end
      endcase
    end
  end

  // frequency settle flag, restarted by startup and frequency writes
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      settle_cnt_reg <= '0;
      settle_done_reg <= 1'b0;
    end
    else if (!running || wr_dac || wr_ofs)
    begin
      settle_cnt_reg <= '0;
      settle_done_reg <= 1'b0;
    end
    else if (settle_cnt_reg != 32'(SETTLE_CYC))
      settle_cnt_reg <= settle_cnt_reg + 32'd1;
    else
      settle_done_reg <= 1'b1;
  end

  // out_gate takes effect only while the divided clock is low, so no runt pulse; sleep entry drops the gate at once
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      active_reg <= 1'b0;
    else if (!running || sleep_go)
      active_reg <= 1'b0; // drop with the sleep entry so no pulse leaks into power-down
    else if (!bus_if.div_lvl)
      active_reg <= out_gate;
  end

  // pin flops
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      spread_q_reg <= 1'b0;
      clk_out_reg <= 1'b0;
      clk_out_oe_n_reg <= 1'b1;
      sda_oe_n_reg <= 1'b1;
      rx_byte_reg <= '0;
      rx_valid_reg <= 1'b0;
    end
    else
    begin
      spread_q_reg <= spread_en;
      clk_out_reg <= active_reg && bus_if.div_lvl;
      clk_out_oe_n_reg <= !(active_reg || idle_low);
      sda_oe_n_reg <= !bus_if.sda_pull;
      rx_byte_reg <= bus_if.rx_byte;
      rx_valid_reg <= bus_if.rx_valid;
    end
  end

  assign hreadyout = hreadyout_reg;
  assign hrdata = hrdata_reg;
  assign hresp = 1'b0;
  assign sda_out = 1'b0;
  assign clk_out = clk_out_reg;
  assign clk_out_oe_n = clk_out_oe_n_reg;
  assign sda_oe_n = sda_oe_n_reg;
  assign rx_byte = rx_byte_reg;
  assign rx_valid = rx_valid_reg;

  property p_sleep_idle;
    @(posedge clk) disable iff (rst) (pwr_reg == dosc_pkg::DOSC_SLEEP) |=> !clk_out && !active_reg;
  endproperty
  a_sleep_idle: assert property (p_sleep_idle) else $error("output active in power-down");

  property p_idle_pin;
    @(posedge clk) disable iff (rst) !active_reg |=> (clk_out_oe_n == !$past(idle_low)) && !clk_out;
  endproperty
  a_idle_pin: assert property (p_idle_pin) else $error("idle pin state wrong");

  property p_gate_off;
    @(posedge clk) disable iff (rst) (active_reg && !out_gate && !bus_if.div_lvl) |=> !active_reg;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("output not disabled by gate");

  property p_gate_on;
    @(posedge clk) disable iff (rst) (running && out_gate && !bus_if.div_lvl && !sleep_go) |=> active_reg;
  endproperty
  a_gate_on: assert property (p_gate_on) else $error("output not enabled by gate");

  property p_osc_keeps;
    @(posedge clk) disable iff (rst) (running && osc_sleep_n) |=> running && bus_if.osc_run;
  endproperty
  a_osc_keeps: assert property (p_osc_keeps) else $error("oscillator stopped while awake");

  property p_no_runt;
    @(posedge clk) disable iff (rst) $rose(active_reg) |-> !$past(bus_if.div_lvl);
  endproperty
  a_no_runt: assert property (p_no_runt) else $error("output enabled mid-pulse");

  property p_startup;
    @(posedge clk) disable iff (rst) $rose(running) |-> $past(start_cnt_reg) == START_LAST && $past(bus_if.tick);
  endproperty
  a_startup: assert property (p_startup) else $error("run entered before startup count");

  property p_sleep_enter;
    @(posedge clk) disable iff (rst) $rose(pwr_reg == dosc_pkg::DOSC_SLEEP) |->
      $past(filt_cnt_reg) == FILT_LAST && !$past(osc_sleep_n) ##1 !bus_if.osc_run;
  endproperty
  a_sleep_enter: assert property (p_sleep_enter) else $error("power-down without deglitch");

  property p_spread;
    @(posedge clk) disable iff (rst) ##1 bus_if.spread == $past(spread_en);
  endproperty
  a_spread: assert property (p_spread) else $error("dither enable not following pin");

  property p_sda_edge;
    @(posedge clk) disable iff (rst) $changed(sda_oe_n) |-> !$past(scl, 2) && $past(scl, 3);
  endproperty
  a_sda_edge: assert property (p_sda_edge) else $error("sda changed off a falling scl");

  property p_sda_od;
    @(posedge clk) disable iff (rst) !sda_oe_n |-> !sda_out && $past(bus_if.sda_pull);
  endproperty
  a_sda_od: assert property (p_sda_od) else $error("sda driven other than low");
endmodule
`default_nettype wire

// File: dosc_consts.svh
`ifndef DOSC_CONSTS_SVH
`define DOSC_CONSTS_SVH

// register indices; the byte address is four times the index
`define DOSC_IDX_PRESCALE 8'h02
`define DOSC_IDX_DAC 8'h08
`define DOSC_IDX_OFFSET 8'h0e
`define DOSC_IDX_STATUS 8'h10

// prescale word fields and the dac field position
`define DOSC_PS_RATE_LSB 14
`define DOSC_PS_PCT_LSB 11
`define DOSC_PS_IDLE_BIT 10
`define DOSC_PS_DIV_LSB 6
`define DOSC_DAC_LSB 6

// reset values
`define DOSC_PS_RST 16'h6000
`define DOSC_DAC_RST 10'h1f4
`define DOSC_OFS_RST 5'h0c

// model constants
`define DOSC_DIV_MAX 4'h8
`define DOSC_OFS_STEP 16'h0040
`define DOSC_INC_BASE 16'h0800

// timing
`define DOSC_CLK_MHZ 50
`define DOSC_STARTUP_TICKS 512
`define DOSC_SLEEP_FILT_NS 10000
`define DOSC_SLEEP_PERIODS 2
`define DOSC_SETTLE_US 100

`endif

// File: dosc_pkg.sv
`default_nettype none
package dosc_pkg;
  // power sequencing of the master oscillator
  typedef enum logic [1:0] {
    DOSC_SLEEP,
    DOSC_STARTUP,
    DOSC_RUN
  } dosc_pwr_t;
endpackage
`default_nettype wire

// File: dosc_if.sv
`timescale 1ns/1ns
`default_nettype none
interface dosc_if;
  // oscillator configuration and status
  logic osc_run;
  logic spread;
  logic [1:0] rate;
  logic [2:0] pct;
  logic [3:0] div;
  logic [9:0] dac;
  logic [4:0] ofs;
  logic tick;
  logic div_lvl;
  // serial bit engine
  logic scl;
  logic sda_in;
  logic [7:0] tx_byte;
  logic tx_en;
  logic [7:0] rx_byte;
  logic rx_valid;
  logic sda_pull;

  modport osc (input osc_run, spread, rate, pct, div, dac, ofs, output tick, div_lvl);
  modport osc_ctl (output osc_run, spread, rate, pct, div, dac, ofs, input tick, div_lvl);
  modport ser (input scl, sda_in, tx_byte, tx_en, output rx_byte, rx_valid, sda_pull);
  modport ser_ctl (output scl, sda_in, tx_byte, tx_en, input rx_byte, rx_valid, sda_pull);
endinterface
`default_nettype wire

// File: dosc_osc.sv
`timescale 1ns/1ns
`default_nettype none
`include "dosc_consts.svh"
module dosc_osc #(
  parameter int ACC_W = 20
) (
  input wire logic clk,
  input wire logic rst,
  dosc_if.osc p
);
  logic [ACC_W-1:0] acc_reg;
  logic [12:0] tri_ctr_reg;
  logic [7:0] div_cnt_reg;
  logic tick_reg;
  logic lvl_reg;

  // frequency word comes only from offset and dac; prescale only divides
  wire [15:0] base_inc = 16'(`DOSC_INC_BASE + 16'(p.ofs) * `DOSC_OFS_STEP + 16'(p.dac));
  wire [1:0] rate_sh = (p.rate == 2'b11) ? 2'b10 : p.rate;
  wire [12:0] phase = 13'(tri_ctr_reg << rate_sh);
  wire [11:0] tri_v = phase[12] ? ~phase[11:0] : phase[11:0];
  // reserved percentage codes fall back to the smallest depth
  wire [2:0] pct_sh = (p.pct == 3'b001) ? 3'd1 : (p.pct == 3'b010) ? 3'd2 :
                      (p.pct == 3'b100) ? 3'd3 : (p.pct == 3'b111) ? 3'd4 : 3'd0;
  wire [15:0] dev = 16'({4'h0, tri_v} >> (3'd7 - pct_sh));
  // dither only pulls the frequency down, never up
  wire [15:0] inc = p.spread ? 16'(base_inc - dev) : base_inc;
  wire [ACC_W:0] sum = {1'b0, acc_reg} + (ACC_W+1)'(inc);
  wire [3:0] div_sel = (p.div > `DOSC_DIV_MAX) ? `DOSC_DIV_MAX : p.div;
  // exponent 0 passes the master square wave itself; a tick counter bit would halve it
  wire lvl_sel = (div_sel == 4'd0) ? acc_reg[ACC_W-1] : div_cnt_reg[3'(div_sel - 4'd1)];

  // phase accumulator, triangle and prescale counters; cleared while stopped
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      acc_reg <= '0;
      tick_reg <= 1'b0;
      tri_ctr_reg <= '0;
      div_cnt_reg <= '0;
      lvl_reg <= 1'b0;
    end
    else if (!p.osc_run)
    begin
      acc_reg <= '0;
      tick_reg <= 1'b0;
      tri_ctr_reg <= '0;
      div_cnt_reg <= '0;
      lvl_reg <= 1'b0;
    end
    else
    begin
      acc_reg <= sum[ACC_W-1:0];
      tick_reg <= sum[ACC_W];
      if (tick_reg)
      begin
        tri_ctr_reg <= tri_ctr_reg + 13'd1;
        div_cnt_reg <= div_cnt_reg + 8'd1;
      end
      lvl_reg <= lvl_sel;
    end
  end

  assign p.tick = tick_reg;
  assign p.div_lvl = lvl_reg;
endmodule
`default_nettype wire

// File: dosc_ser.sv
`timescale 1ns/1ns
`default_nettype none
module dosc_ser (
  input wire logic clk,
  input wire logic rst,
  dosc_if.ser p
);
  logic scl_q_reg;
  logic sda_q_reg;
  logic [7:0] rx_sh_reg;
  logic [7:0] tx_sh_reg;
  logic [2:0] cnt_reg;
  logic [7:0] rx_byte_reg;
  logic rx_valid_reg;
  logic pull_reg;

  // edge and start detection from the previous line levels
  wire scl_rise = p.scl && !scl_q_reg;
  wire scl_fall = !p.scl && scl_q_reg;
  wire start_cond = p.scl && scl_q_reg && sda_q_reg && !p.sda_in;

  // shift in on rising edges, shift out after falling edges
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
      rx_sh_reg <= '0;
      tx_sh_reg <= '0;
      cnt_reg <= '0;
      rx_byte_reg <= '0;
      rx_valid_reg <= 1'b0;
      pull_reg <= 1'b0;
    end
    else
    begin
      scl_q_reg <= p.scl;
      sda_q_reg <= p.sda_in;
      rx_valid_reg <= 1'b0;
      if (start_cond)
      begin
        cnt_reg <= '0;
        tx_sh_reg <= p.tx_byte;
      end
      else if (scl_rise)
      begin
        rx_sh_reg <= {rx_sh_reg[6:0], p.sda_in};
        cnt_reg <= cnt_reg + 3'd1;
        if (cnt_reg == 3'd7)
        begin
          rx_byte_reg <= {rx_sh_reg[6:0], p.sda_in};
          rx_valid_reg <= 1'b1;
        end
      end
      if (!p.tx_en)
        pull_reg <= 1'b0;
      else if (scl_fall && !start_cond)
      begin
        pull_reg <= !tx_sh_reg[7];
        tx_sh_reg <= {tx_sh_reg[6:0], 1'b1};
      end
    end
  end

  assign p.rx_byte = rx_byte_reg;
  assign p.rx_valid = rx_valid_reg;
  assign p.sda_pull = pull_reg;
endmodule
`default_nettype wire

// File: dosc_host.sv
`timescale 1ns/1ns
`default_nettype none
module dosc_host (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_pull
);
  // scl rests high between frames, so no stray edges reach the device
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // start, then 8 bits msb first; half sets the pace, scl left high after
  task automatic xfer(input logic [7:0] tx, input int half, output logic [7:0] rx);
    sda_pull <= 1'b0;
    repeat (half) @(posedge clk);
    sda_pull <= 1'b1;
    repeat (half) @(posedge clk);
    for (int i = 7; i >= 0; i--)
    begin
      scl <= 1'b0;
      repeat (2) @(posedge clk);
      sda_pull <= ~tx[i];
      repeat (half) @(posedge clk);
      scl <= 1'b1;
      repeat (half) @(posedge clk);
      rx[i] = sda_line;
    end
  endtask
endmodule
`default_nettype wire

// File: dosc_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "dosc_consts.svh"
`define CHK(nm, exp, got) \
  begin \
    checked++; \
    if ((got) !== (exp)) \
    begin \
      n_fail++; \
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); \
    end \
  end
module dithered_osc_output_control_bench;
  localparam int SETTLE = 20;
  localparam int D0 = `DOSC_DAC_RST;
  localparam int O0 = `DOSC_OFS_RST;
  localparam logic [31:0] A_PS = {22'h0, `DOSC_IDX_PRESCALE, 2'b00};
  localparam logic [31:0] A_DAC = {22'h0, `DOSC_IDX_DAC, 2'b00};
  localparam logic [31:0] A_OFS = {22'h0, `DOSC_IDX_OFFSET, 2'b00};
  localparam logic [31:0] A_ST = {22'h0, `DOSC_IDX_STATUS, 2'b00};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic spread_en = 1'b0;
  logic out_gate = 1'b1;
  logic osc_sleep_n = 1'b1;
  wire logic hreadyout, hresp, sda_out, sda_oe_n, clk_out, clk_out_oe_n, rx_valid, scl, sda_pull, sda_line;
  wire logic [31:0] hrdata;
  wire logic [7:0] rx_byte;
  int n_fail = 0;
  int checked = 0;
  int cyc = 0;
  int hi_len = 0;
  int min_hi = 0;
  int n_rx = 0;

  // sda has a pull-up; any party pulling wins
  assign sda_line = ~(sda_pull | (~sda_oe_n & ~sda_out));

  always #10 clk = ~clk;

  dosc_top #(.ACC_W(16), .SETTLE_CYC(SETTLE)) DUT (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .spread_en(spread_en), .out_gate(out_gate),
    .osc_sleep_n(osc_sleep_n), .scl(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .clk_out(clk_out), .clk_out_oe_n(clk_out_oe_n), .rx_byte(rx_byte), .rx_valid(rx_valid));

  dosc_host host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_pull(sda_pull));

  // cycle count, received-byte pulses, and high-phase width of the output
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (rx_valid === 1'b1)
      n_rx++;
    if (clk_out === 1'b1)
      hi_len <= hi_len + 1;
    else
    begin
      if (hi_len != 0 && min_hi != 0)
        `CHK("high phase", 1'b1, hi_len >= min_hi)
      hi_len <= 0;
    end
  end

  // clk cycles spent on a given number of oscillator ticks
  function automatic int cyc_for(input int ticks, input int dac, input int ofs);
    return ticks * 65536 / (`DOSC_INC_BASE + ofs * `DOSC_OFS_STEP + dac);
  endfunction

  // one single transfer; waits for hready in both phases, no fixed latency assumed
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0000_0000, x);
    `CHK(nm, e, x & m)
  endtask

  // cycles until the pin is driven again; bounded so a dead output still returns
  task automatic startup(input string nm, input int lo, input int hi);
    int t0;
    t0 = cyc;
    while (clk_out_oe_n !== 1'b0 && cyc - t0 < hi + 100) @(posedge clk);
    `CHK(nm, 1'b1, (cyc - t0 >= lo) && (cyc - t0 <= hi))
  endtask

  task automatic period8(input string nm, input int e);
    int t0;
    // skip two edges: a prescale switch may leave an odd first period
    repeat (2) @(posedge clk_out);
    t0 = cyc;
    repeat (8) @(posedge clk_out);
    `CHK(nm, 1'b1, (cyc - t0 >= e - 3) && (cyc - t0 <= e + 3))
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // main sequence
  initial
  begin
    int hold;
    logic [7:0] hrx;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rchk("ps rst", A_PS, 32'hffff_ffff, 32'h0000_6000);
    rchk("dac rst", A_DAC, 32'hffff_ffff, 32'h0000_7d00);
    rchk("ofs rst", A_OFS, 32'hffff_ffff, 32'h0000_00ec);
    wr(32'h0000_00fc, 32'hffff_ffff);
    rchk("unmapped", 32'h0000_00fc, 32'hffff_ffff, 32'h0000_0000);
    `CHK("okay resp", 1'b0, hresp)
    `CHK("float at start", 1'b1, clk_out_oe_n)
    startup("power-up", cyc_for(512, D0, O0) - 40, cyc_for(514, D0, O0) + 40);
    wr(A_PS, 32'h0000_6080);
    period8("div4", cyc_for(32, D0, O0));
    // armed after the prescale switch; sized for the fastest setting used below
    min_hi = cyc_for(2, D0, 16) - 2;
    wr(A_DAC, 32'h0000_0000);
    rchk("settle cleared", A_ST, 32'hffff_ffff, 32'h0000_0006);
    repeat (SETTLE + 5) @(posedge clk);
    rchk("settle done", A_ST, 32'hffff_ffff, 32'h0000_000e);
    period8("dac 0", cyc_for(32, 0, O0));
    wr(A_OFS, 32'h0000_0010);
    period8("ofs 16", cyc_for(32, D0 * 0, 16));
    wr(A_DAC, 32'h0000_7d00);
    period8("dac+ofs", cyc_for(32, D0, 16));
    wr(A_OFS, 32'h0000_000c);
    repeat (SETTLE + 5) @(posedge clk);
    spread_en <= 1'b1;
    repeat (3) @(posedge clk);
    rchk("dither on", A_ST, 32'hffff_ffff, 32'h0000_001e);
    spread_en <= 1'b0;
    repeat (3) @(posedge clk);
    rchk("dither off", A_ST, 32'hffff_ffff, 32'h0000_000e);
    period8("plain clock", cyc_for(32, D0, O0));
    // gate off: floats, then held low; oscillator keeps running
    out_gate <= 1'b0;
    repeat (cyc_for(8, D0, O0)) @(posedge clk);
    `CHK("gated float", 1'b1, clk_out_oe_n)
    rchk("gated status", A_ST, 32'hffff_ffff, 32'h0000_000a);
    wr(A_PS, 32'h0000_6480);
    repeat (cyc_for(8, D0, O0)) @(posedge clk);
    `CHK("held low oe", 1'b0, clk_out_oe_n)
    `CHK("held low", 1'b0, clk_out)
    out_gate <= 1'b1;
    period8("gate on", cyc_for(32, D0, O0));
    wr(A_PS, 32'h0000_6080);
    // a short sleep request is filtered out
    osc_sleep_n <= 1'b0;
    repeat (100) @(posedge clk);
    osc_sleep_n <= 1'b1;
    rchk("glitch ignored", A_ST, 32'h0000_0003, 32'h0000_0002);
    // held for 10 us plus two output periods
    // sleep entry may cut a pulse short, which is allowed
    min_hi = 0;
    hold = `DOSC_SLEEP_FILT_NS / 20 + `DOSC_SLEEP_PERIODS * cyc_for(4, D0, O0) + 40;
    osc_sleep_n <= 1'b0;
    repeat (hold) @(posedge clk);
    rchk("asleep", A_ST, 32'h0000_0007, 32'h0000_0001);
    repeat (200) @(posedge clk);
    `CHK("sleep idle oe", 1'b1, clk_out_oe_n)
    `CHK("sleep idle", 1'b0, clk_out)
    osc_sleep_n <= 1'b1;
    startup("restart", cyc_for(512, D0, O0) - 10, cyc_for(520, D0, O0) + 40);
    min_hi = cyc_for(2, D0, 16) - 2;
    period8("after restart", cyc_for(32, D0, O0));
    min_hi = 0;
    // serial: device releases while sending ones, then pulls for zeros
    wr(A_PS, 32'h0000_ff80);
    host.xfer(8'ha5, 8, hrx);
    `CHK("rx fast", 8'ha5, rx_byte)
    `CHK("tx ones", 8'ha5, hrx)
    wr(A_PS, 32'h0000_6080);
    host.xfer(8'hff, 20, hrx);
    `CHK("tx slow", 8'h60, hrx)
    `CHK("rx wired", 8'h60, rx_byte)
    `CHK("drain only", 1'b0, sda_out)
    `CHK("rx pulses", 1'b1, n_rx == 2)
    results();
  end

  // two power-up delays of about ten thousand cycles each dominate the run
  initial
  begin
    repeat (60000) @(posedge clk);
    n_fail++;
    results();
  end
endmodule
`default_nettype wire
